// *** design/rcso_consts.svh ***
// Offsets, field positions, reset values and timing counts
`ifndef RCSO_CONSTS_SVH
`define RCSO_CONSTS_SVH

// Register indices on the CPU register port
`define RCSO_ADDR_CAUSE 2'h0
`define RCSO_ADDR_FORCE 2'h1
`define RCSO_ADDR_OPTS  2'h2

// Reset-cause flag positions
`define RCSO_POR_BIT  7
`define RCSO_PIN_BIT  6
`define RCSO_WDOG_BIT 5
`define RCSO_ILL_BIT  4
`define RCSO_CLK_BIT  2
`define RCSO_LV_BIT   1
`define RCSO_CAUSE_MASK 8'hf6
`define RCSO_CAUSE_POR  8'h82

// Force-reset control
`define RCSO_FORCE_BIT 0
`define RCSO_FORCE_READ 8'h00

// Options layout and defaults
`define RCSO_WDEN_BIT 7
`define RCSO_WDTO_BIT 6
`define RCSO_HALT_BIT 5
`define RCSO_DPIN_BIT 1
`define RCSO_OPTS_MASK 8'he2
`define RCSO_OPTS_RST  8'hc2

// Watchdog periods in bus clocks
`define RCSO_WDOG_SHORT_CYC 8192
`define RCSO_WDOG_LONG_CYC  262144

// Least width of the system reset pulse
`define RCSO_CLK_MHZ 40
`define RCSO_HOLD_NS 200
`define RCSO_HOLD_CYC ((`RCSO_HOLD_NS * `RCSO_CLK_MHZ + 999) / 1000)

`endif

// *** design/rcso_pkg.sv ***
// Types shared by the reset-cause and options logic
package rcso_pkg;

	// One-hot sequencer states
	typedef enum logic [1:0]
	{
		RCSO_RUN  = 2'b01,
		RCSO_HOLD = 2'b10
	} rcso_state_t;

	typedef logic [7:0] rcso_byte_t;

endpackage

// *** design/rcso_src_if.sv ***
// Reset sources passed to the qualifier and the qualified result it returns
`timescale 1ns/1ps

interface rcso_src_if;
	import rcso_pkg::*;

	logic       pin_low;
	logic       wdog_to;
	logic       wdog_en;
	logic       unimpl;
	logic       halt_exec;
	logic       halt_en;
	logic       background_instruction_exec;
	logic       background_instruction_en;
	logic       clk_req;
	logic       lv_trip;
	logic       lv_en;
	logic       lv_ren;
	logic       lv_halt_en;
	logic       in_halt;
	logic       force_rst;
	logic       prior_por;
	logic       req;
	rcso_byte_t next_cause;

	modport src
	(
		output pin_low, wdog_to, wdog_en, unimpl, halt_exec, halt_en,
		output background_instruction_exec, background_instruction_en, clk_req, lv_trip, lv_en, lv_ren,
		output lv_halt_en, in_halt, force_rst, prior_por,
		input  req, next_cause
	);

	modport qual
	(
		input  pin_low, wdog_to, wdog_en, unimpl, halt_exec, halt_en,
		input  background_instruction_exec, background_instruction_en, clk_req, lv_trip, lv_en, lv_ren,
		input  lv_halt_en, in_halt, force_rst, prior_por,
		output req, next_cause
	);

endinterface

// *** design/rcso_src_qual.sv ***
// Qualifies reset sources and forms the next reset-cause byte
`timescale 1ns/1ps
`include "rcso_consts.svh"

module rcso_src_qual
	import rcso_pkg::*;
(
	rcso_src_if.qual s    // Sources in, request and cause out
);

	logic lv_rst;
	logic wd_rst;
	logic ill_rst;
	logic other_rst;

	// Low-voltage trip only counts with both enables, and in halt only
	// when detection is kept alive there
	assign lv_rst = s.lv_trip & s.lv_en & s.lv_ren &
		(~s.in_halt | s.lv_halt_en);
	assign wd_rst = s.wdog_to & s.wdog_en;
	assign ill_rst = s.unimpl | (s.halt_exec & ~s.halt_en) |
		(s.background_instruction_exec & ~s.background_instruction_en);
	assign other_rst = s.pin_low | wd_rst | ill_rst | s.clk_req;

	assign s.req = s.force_rst | lv_rst | other_rst;

	// Cause byte: every active source recorded, the rest cleared; a force reset clears every flag
	always_comb
	begin
		s.next_cause = 8'h00;
		if (!s.force_rst)
		begin
			s.next_cause[`RCSO_PIN_BIT] = s.pin_low;
			s.next_cause[`RCSO_WDOG_BIT] = wd_rst;
			s.next_cause[`RCSO_ILL_BIT] = ill_rst;
			s.next_cause[`RCSO_CLK_BIT] = s.clk_req;
			s.next_cause[`RCSO_LV_BIT] = lv_rst;
			// A lone low-voltage reset leaves the power-on flag alone
			s.next_cause[`RCSO_POR_BIT] = lv_rst & ~other_rst &
				s.prior_por;
		end
	end

endmodule

// *** design/rcso_top.sv ***
// Reset-cause flags, debug force reset and write-once system options
`timescale 1ns/1ps
`include "rcso_consts.svh"

module rcso_top
	import rcso_pkg::*;
#(
	parameter logic [18:0] WDOG_SHORT_CYC = 19'(`RCSO_WDOG_SHORT_CYC),
	parameter logic [18:0] WDOG_LONG_CYC  = 19'(`RCSO_WDOG_LONG_CYC)
)
(
	input  wire logic        clk_i,                     // Bus clock
	input  wire logic        resetn_i,                  // Power-on reset
	input  wire logic [1:0]  reg_addr_i,                // Register index
	input  wire logic        reg_wr_i,                  // Write strobe
	input  wire logic        reg_rd_i,                  // Read strobe
	input  wire logic [7:0]  reg_wdata_i,               // Write data
	input  wire logic        reg_dbg_i,                 // Access by debug
	output logic      [7:0]  reg_rdata_o,               // Read data
	input  wire logic        ext_reset_n_i,             // Reset pin level
	input  wire logic        wdog_timeout_i,            // Watchdog expired
	input  wire logic        unimpl_opcode_i,           // Bad opcode run
	input  wire logic        halt_exec_i,               // Halt executed
	input  wire logic        background_instruction_exec_i,               // Background instr
	input  wire logic        background_mode_enable_i,  // Background on
	input  wire logic        clk_gen_reset_req_i,       // Clock gen reset
	input  wire logic        low_voltage_trip_i,        // Supply below trip
	input  wire logic        low_voltage_detect_enable_i, // Detector on
	input  wire logic        low_voltage_reset_enable_i,  // Trip resets
	input  wire logic        low_voltage_in_halt_enable_i, // Kept in halt
	input  wire logic        in_halt_i,                 // Chip is halted
	output logic             sys_reset_o,               // System reset
	output logic             wdog_restart_o,            // Restart pulse
	output logic             watchdog_enable_o,         // Watchdog on
	output logic             watchdog_timeout_select_o, // Long timeout
	output logic      [18:0] wdog_limit_o,              // Timeout cycles
	output logic             halt_mode_enable_o,        // Halt allowed
	output logic             debug_pin_enable_o         // Pin is debug
);

	rcso_state_t state;
	rcso_state_t next_state;
	logic [3:0]  hold_cnt;
	rcso_byte_t  cause;
	rcso_byte_t  opts;
	logic        opts_locked;
	logic        running;
	logic        wr_cause;
	logic        wr_force;
	logic        wr_opts;
	logic        force_rst;

	rcso_src_if src ();

	// Shared index compare for the read and write paths
	function automatic logic hit(input logic [1:0] a, input logic [1:0] t);
		hit = (a == t);
	endfunction

	// Register access is only served while the system runs
	assign running = (state == RCSO_RUN);

	// Write decode, one chain per access kind
	always_comb
	begin
		wr_cause = 1'b0;
		wr_force = 1'b0;
		wr_opts = 1'b0;
		if (running && reg_wr_i)
		begin
			if (hit(reg_addr_i, `RCSO_ADDR_CAUSE))
				wr_cause = 1'b1;
			else if (hit(reg_addr_i, `RCSO_ADDR_FORCE))
				wr_force = 1'b1;
			else if (hit(reg_addr_i, `RCSO_ADDR_OPTS))
				wr_opts = 1'b1;
		end
	end

	// Program writes to the force register fall away here
	assign force_rst = wr_force & reg_dbg_i &
		reg_wdata_i[`RCSO_FORCE_BIT];

	// Sources toward the qualifier; event inputs only sampled while running, enables, in_halt and the power-on flag passed ungated
	assign src.pin_low = running & ~ext_reset_n_i;
	assign src.wdog_to = running & wdog_timeout_i;
	assign src.wdog_en = opts[`RCSO_WDEN_BIT];
	assign src.unimpl = running & unimpl_opcode_i;
	assign src.halt_exec = running & halt_exec_i;
	assign src.halt_en = opts[`RCSO_HALT_BIT];
	assign src.background_instruction_exec = running & background_instruction_exec_i;
	assign src.background_instruction_en = background_mode_enable_i;
	assign src.clk_req = running & clk_gen_reset_req_i;
	assign src.lv_trip = running & low_voltage_trip_i;
	assign src.lv_en = low_voltage_detect_enable_i;
	assign src.lv_ren = low_voltage_reset_enable_i;
	assign src.lv_halt_en = low_voltage_in_halt_enable_i;
	assign src.in_halt = in_halt_i;
	assign src.force_rst = force_rst;
	assign src.prior_por = cause[`RCSO_POR_BIT];

	rcso_src_qual u_qual
	(
		.s (src.qual)
	);

	// Sequencer: a reset request opens a stretched reset window
	always_comb
	begin
		next_state = state;
		case (state)
			RCSO_RUN:
			begin
				if (src.req)
					next_state = RCSO_HOLD;
			end
			RCSO_HOLD:
			begin
				// A pin held low keeps the chip in reset past the minimum
				if (hold_cnt == 4'h0 && ext_reset_n_i)
					next_state = RCSO_RUN;
			end
			default:
				next_state = RCSO_HOLD;
		endcase
	end

	// State register; power-on also passes through the hold window
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			state <= RCSO_HOLD;
		else
			state <= next_state;
	end

	// Minimum reset width counter
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			hold_cnt <= 4'(`RCSO_HOLD_CYC - 1);
		else if (running && src.req)
			hold_cnt <= 4'(`RCSO_HOLD_CYC - 1);
		else if (hold_cnt != 4'h0)
			hold_cnt <= hold_cnt - 4'h1;
	end

	// System reset output follows the next state so it has no lag
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			sys_reset_o <= 1'b1;
		else
			sys_reset_o <= (next_state == RCSO_HOLD);
	end

	// Cause flags are captured once, as the reset is entered
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cause <= `RCSO_CAUSE_POR;
		else if (running && src.req)
			cause <= src.next_cause & `RCSO_CAUSE_MASK;
	end

	// Any write to the cause index kicks the watchdog; flags untouched
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			wdog_restart_o <= 1'b0;
		else
			wdog_restart_o <= wr_cause;
	end

	// Write-once options; every system reset rearms them to defaults
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			opts <= `RCSO_OPTS_RST;
			opts_locked <= 1'b0;
		end
		else if (!running)
		begin
			opts <= `RCSO_OPTS_RST;
			opts_locked <= 1'b0;
		end
		else if (wr_opts && !opts_locked)
		begin
			// Unused bits never store, so they always read zero
			opts <= reg_wdata_i & `RCSO_OPTS_MASK;
			opts_locked <= 1'b1;
		end
	end

	// Watchdog period follows the timeout select
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			wdog_limit_o <= 19'(`RCSO_WDOG_LONG_CYC);
		else if (opts[`RCSO_WDTO_BIT])
			wdog_limit_o <= WDOG_LONG_CYC;
		else
			wdog_limit_o <= WDOG_SHORT_CYC;
	end

	// Read path, one cycle of latency; unmapped indices read zero
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			reg_rdata_o <= 8'h00;
		else if (running && reg_rd_i)
		begin
			if (hit(reg_addr_i, `RCSO_ADDR_CAUSE))
				reg_rdata_o <= cause & `RCSO_CAUSE_MASK;
			else if (hit(reg_addr_i, `RCSO_ADDR_FORCE))
				reg_rdata_o <= `RCSO_FORCE_READ;
			else if (hit(reg_addr_i, `RCSO_ADDR_OPTS))
				reg_rdata_o <= opts & `RCSO_OPTS_MASK;
			else
				reg_rdata_o <= 8'h00;
		end
	end

	// Option outputs come straight from the option flip-flops
	assign watchdog_enable_o = opts[`RCSO_WDEN_BIT];
	assign watchdog_timeout_select_o = opts[`RCSO_WDTO_BIT];
	assign halt_mode_enable_o = opts[`RCSO_HALT_BIT];
	assign debug_pin_enable_o = opts[`RCSO_DPIN_BIT];

endmodule

// *** testbench/rcso_host_model.sv ***
// CPU software and debug host driving the register port
`timescale 1ns/1ps

module rcso_host_model
	import rcso_pkg::*;
(
	input  wire logic       clk_i,   // Bus clock
	input  wire logic [7:0] rdata_i, // Read data
	output logic      [1:0] addr_o,  // Index
	output logic            wr_o,    // Write strobe
	output logic            rd_o,    // Read strobe
	output logic      [7:0] wdata_o, // Write data
	output logic            dbg_o    // Access from debug path
);
	// Port idle from time zero
	initial
	begin
		{addr_o, wr_o, rd_o, wdata_o, dbg_o} = '0;
	end

	// One-cycle access; index and data are inverted after release so a
	// stale value can never pass for a held one
	task automatic access(input logic [1:0] a, input logic w,
		input rcso_byte_t d, input logic g);
		@(negedge clk_i);
		addr_o = a;
		wr_o = w;
		rd_o = !w;
		wdata_o = d;
		dbg_o = g;
		@(negedge clk_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
		dbg_o = 1'b0;
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
	endtask

	task automatic wr(input logic [1:0] a, input rcso_byte_t d,
		input logic g);
		access(a, 1'b1, d, g);
	endtask

	// Data is registered, so it is taken one edge after the strobe drops
	task automatic rd(input logic [1:0] a, output rcso_byte_t d);
		access(a, 1'b0, 8'h00, 1'b0);
		@(negedge clk_i);
		d = rdata_i;
	endtask
endmodule

// *** testbench/rcso_top_sva.sv ***
// Checker for the reset-cause and options block ports
`timescale 1ns/1ps

module rcso_top_sva
	import rcso_pkg::*;
#(
	parameter logic [18:0] WDOG_SHORT_CYC = 19'd8192,
	parameter logic [18:0] WDOG_LONG_CYC  = 19'd262144
)
(
	input wire logic        clk_i,                     // Clock
	input wire logic        resetn_i,                  // Reset
	input wire logic [1:0]  reg_addr_i,                // Index
	input wire logic        reg_wr_i,                  // Write
	input wire logic        reg_rd_i,                  // Read
	input wire logic [7:0]  reg_wdata_i,               // Data in
	input wire logic        reg_dbg_i,                 // Debug path
	input wire logic [7:0]  reg_rdata_o,               // Data out
	input wire logic        wdog_timeout_i,            // Timeout
	input wire logic        sys_reset_o,               // Reset out
	input wire logic        wdog_restart_o,            // Restart
	input wire logic        watchdog_enable_o,         // Enable
	input wire logic        watchdog_timeout_select_o, // Long period
	input wire logic [18:0] wdog_limit_o               // Period
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	// Accesses only count outside the reset hold
	wire logic rd_ok = !sys_reset_o && reg_rd_i && !reg_wr_i;
	wire logic wr_ok = !sys_reset_o && reg_wr_i;

	restart_on_write_a: assert property (wr_ok && reg_addr_i == 2'h0 |=>
		wdog_restart_o) else $error("no restart after cause write");
	force_reads_zero_a: assert property (rd_ok && reg_addr_i == 2'h1 |=>
		reg_rdata_o == 8'h00) else $error("force register read not zero");
	opts_gap_zero_a: assert property (rd_ok && reg_addr_i == 2'h2 |=>
		reg_rdata_o[3:2] == 2'b00) else $error("options gap bits set");
	cause_gap_zero_a: assert property (rd_ok && reg_addr_i == 2'h0 |=>
		(reg_rdata_o & 8'h09) == 8'h00) else $error("cause gap bits set");
	wdog_reset_a: assert property (!sys_reset_o && wdog_timeout_i &&
		watchdog_enable_o |=> sys_reset_o) else $error("no watchdog reset");
	force_reset_a: assert property (wr_ok && reg_dbg_i &&
		reg_addr_i == 2'h1 && reg_wdata_i[0] |=> sys_reset_o[*8])
		else $error("debug force reset missing or short");
	opts_default_a: assert property ($rose(sys_reset_o) |=>
		watchdog_enable_o && watchdog_timeout_select_o)
		else $error("options not back to defaults");
	limit_follows_a: assert property ($stable(watchdog_timeout_select_o)
		|-> wdog_limit_o == (watchdog_timeout_select_o ? WDOG_LONG_CYC :
		WDOG_SHORT_CYC)) else $error("watchdog period mismatch");

	// Main scenarios reached
	cover property ($fell(sys_reset_o));
	cover property (wdog_restart_o);
	cover property (!watchdog_enable_o && wdog_timeout_i);
endmodule

bind rcso_top rcso_top_sva #(.WDOG_SHORT_CYC(WDOG_SHORT_CYC),
	.WDOG_LONG_CYC(WDOG_LONG_CYC)) sva (.clk_i(clk_i), .resetn_i(resetn_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_wdata_i(reg_wdata_i), .reg_dbg_i(reg_dbg_i),
	.reg_rdata_o(reg_rdata_o), .wdog_timeout_i(wdog_timeout_i),
	.sys_reset_o(sys_reset_o), .wdog_restart_o(wdog_restart_o),
	.watchdog_enable_o(watchdog_enable_o),
	.watchdog_timeout_select_o(watchdog_timeout_select_o),
	.wdog_limit_o(wdog_limit_o));

// *** testbench/tb.sv ***
// Bench for reset-cause flags, debug force reset and write-once options
`timescale 1ns/1ps
`include "rcso_consts.svh"

module tb
	import rcso_pkg::*;
;
	logic        clk_i    = 1'b0;
	logic        resetn_i = 1'b0;
	logic [11:0] src      = 12'h001;
	logic [1:0]  addr;
	logic        wr, rd, dbg, sys, wden, wdsel, halt, dpin;
	logic [7:0]  wdata, rdata;
	logic [18:0] limit;
	int          num_errors = 0;
	int          checks     = 0;

	// Bus clock
	always #12.5 clk_i = ~clk_i;

	rcso_host_model host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
		.wr_o(wr), .rd_o(rd), .wdata_o(wdata), .dbg_o(dbg));

	// Source bits: pin_n, wdog, opcode, halt, background_instruction, background_instruction_en, clkgen, trip,
	// det_en, rst_en, lv_halt_en, in_halt
	rcso_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_dbg_i(dbg),
		.reg_rdata_o(rdata), .ext_reset_n_i(src[0]),
		.wdog_timeout_i(src[1]), .unimpl_opcode_i(src[2]),
		.halt_exec_i(src[3]), .background_instruction_exec_i(src[4]),
		.background_mode_enable_i(src[5]), .clk_gen_reset_req_i(src[6]),
		.low_voltage_trip_i(src[7]), .low_voltage_detect_enable_i(src[8]),
		.low_voltage_reset_enable_i(src[9]),
		.low_voltage_in_halt_enable_i(src[10]), .in_halt_i(src[11]),
		.sys_reset_o(sys), .wdog_restart_o(), .watchdog_enable_o(wden),
		.watchdog_timeout_select_o(wdsel), .wdog_limit_o(limit),
		.halt_mode_enable_o(halt), .debug_pin_enable_o(dpin));

	task automatic finish_test();
		$display("Errors %0d, checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [18:0] got, input logic [18:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [1:0] a, input rcso_byte_t exp);
		rcso_byte_t v;
		host.rd(a, v);
		chk(19'(v), 19'(exp));
	endtask

	// Waits a few edges for reset entry, then a bounded time for release
	task automatic settle(input logic exp);
		int n;
		n = 0;
		while (sys !== 1'b1 && n < 4)
		begin
			@(negedge clk_i);
			n++;
		end
		chk(19'(sys), 19'(exp));
		n = 0;
		while (sys !== 1'b0 && n < 40)
		begin
			@(negedge clk_i);
			n++;
		end
		if (n == 40)
		begin
			num_errors++;
			$display("[ERR] %0t reset never released", $time);
			finish_test();
		end
	endtask

	// One-cycle source pattern, then the cause byte read back
	task automatic fire(input logic [11:0] p, input logic r,
		input rcso_byte_t exp);
		@(negedge clk_i);
		src = p;
		@(negedge clk_i);
		src = 12'h001;
		settle(r);
		rchk(2'h0, exp);
	endtask

	initial
	begin
		repeat (10) @(negedge clk_i);
		resetn_i = 1'b1;
		settle(1'b1);
		rchk(2'h0, 8'h82);
		rchk(2'h2, 8'hc2);
		chk({wden, wdsel, halt, dpin}, 4'b1101);
		chk(limit, 19'(`RCSO_WDOG_LONG_CYC));
		host.wr(2'h0, 8'h55, 1'b0);
		rchk(2'h0, 8'h82);
		host.wr(2'h2, 8'h2c, 1'b0);
		host.wr(2'h2, 8'hc3, 1'b0);
		rchk(2'h2, 8'h20);
		chk({wden, wdsel, halt, dpin}, 4'b0010);
		chk(limit, 19'(`RCSO_WDOG_SHORT_CYC));
		fire(12'h003, 1'b0, 8'h82);
		host.wr(2'h1, 8'h01, 1'b0);
		rchk(2'h1, 8'h00);
		chk(19'(sys), 19'h0);
		fire(12'h381, 1'b1, 8'h82);
		rchk(2'h2, 8'hc2);
		chk({wden, wdsel, halt, dpin}, 4'b1101);
		fire(12'h181, 1'b0, 8'h82);
		fire(12'hb81, 1'b0, 8'h82);
		fire(12'h000, 1'b1, 8'h40);
		fire(12'h002, 1'b1, 8'h60);
		fire(12'h005, 1'b1, 8'h10);
		fire(12'h009, 1'b1, 8'h10);
		fire(12'h011, 1'b1, 8'h10);
		fire(12'h031, 1'b0, 8'h10);
		fire(12'h041, 1'b1, 8'h04);
		fire(12'h381, 1'b1, 8'h02);
		fire(12'hf81, 1'b1, 8'h02);
		host.wr(2'h1, 8'h01, 1'b1);
		settle(1'b1);
		rchk(2'h0, 8'h00);
		// Power-on reset again in mid-run must restore the power-on byte
		@(negedge clk_i);
		resetn_i = 1'b0;
		repeat (10) @(negedge clk_i);
		resetn_i = 1'b1;
		settle(1'b1);
		rchk(2'h0, 8'h82);
		rchk(2'h2, 8'hc2);
		finish_test();
	end
endmodule
